// ---- hdl/uies_regs.vh ----
// register offsets, event bit positions and reset values of the event block
`ifndef UIES_REGS_VH
`define UIES_REGS_VH

`define UIES_OFF_STATUS 8'h00
`define UIES_OFF_MASK 8'h04
`define UIES_OFF_CFG 8'h08
`define UIES_OFF_LEVEL 8'h0C

`define UIES_EV_RX_TRIG 0
`define UIES_EV_RX_EMPTY 1
`define UIES_EV_RX_FULL 2
`define UIES_EV_TX_EMPTY 3
`define UIES_EV_TX_FULL 4
`define UIES_EV_RX_OVR 5
`define UIES_EV_RX_FRAME 6
`define UIES_EV_RX_PAR 7
`define UIES_EV_RX_TOUT 8
`define UIES_EV_MODEM 9
`define UIES_EV_TX_TRIG 10
`define UIES_EV_TX_NFULL 11
`define UIES_EV_TX_OVF 12
`define UIES_EV_W 13

`define UIES_CFG_CSIZE_LSB 0
`define UIES_CFG_CSIZE_MSB 1
`define UIES_CFG_TTRIG_LSB 8
`define UIES_CFG_TTRIG_MSB 13
`define UIES_CFG_PAREN 16

`define UIES_CSIZE_PAIR 2'h0
`define UIES_STATUS_RST 13'h0000
`define UIES_MASK_RST 13'h0000
`define UIES_CSIZE_RST 2'h3
`define UIES_TTRIG_RST 6'h20
`define UIES_PAREN_RST 1'h0

`endif

// ---- hdl/uies_top.v ----
// event capture, mask and interrupt logic of a serial port's event status register
//
// Functional notes
// - set bit 12 when a push finds too little transmit room for its data
// - any push while transmit nearly-full is already set raises bit 12
// - set bit 11 when a push leaves no room for one configured-size write
// - character size 00 assumes a two-byte write; a single-byte push then also needs two free bytes
// - set bit 10 when a push makes transmit fill equal the trigger level
// - set bit 9 when any of four modem change indicators becomes set
// - set bit 8 when the receive idle timeout counter expires
// - set bit 7 when received parity differs from expected parity
// - set bit 6 when no valid stop bit ends a received character
// - set bit 5 when a start bit arrives before shifter moved to FIFO
// - set bit 4 when a push takes the transmit FIFO from not full to full
// - set bit 3 when the last word leaves the transmit FIFO
// - set bit 2 when a push takes the receive FIFO from not full to full
// - set bit 1 when the last word leaves the receive FIFO
// - set bit 0 whenever a word enters the receive FIFO
// - event bits read 1 after their event, 0 otherwise; bits 31:13 read zero
// - an event requests an interrupt only while its mask bit is 1
`timescale 1ns/1ps
`include "uies_regs.vh"

module uies_top #(
   parameter TX_DEPTH = 64,
   parameter RX_DEPTH = 64,
   parameter LVL_W = 7
) (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   input wire tx_push_i,
   input wire tx_pair_i,
   input wire tx_pop_i,
   input wire [LVL_W-1:0] tx_level_i,
   input wire rx_push_i,
   input wire rx_pop_i,
   input wire [LVL_W-1:0] rx_level_i,
   input wire rx_start_i,
   input wire rx_shift_pending_i,
   input wire rx_char_done_i,
   input wire rx_parity_bit_i,
   input wire rx_parity_exp_i,
   input wire rx_stop_bit_i,
   input wire rx_timeout_i,
   input wire [3:0] modem_delta_i,
   output reg irq_o,
   output reg tx_nearly_full_o,
   output reg [1:0] char_size_o,
   output reg [5:0] tx_trig_level_o
);

   localparam [LVL_W-1:0] TX_FULL_LVL = TX_DEPTH[LVL_W-1:0];
   localparam [LVL_W-1:0] RX_FULL_LVL = RX_DEPTH[LVL_W-1:0];
   localparam [LVL_W-1:0] ONE_LVL = {{(LVL_W-1){1'b0}}, 1'b1};

   // bytes that one write of the configured size takes
   function [LVL_W-1:0] write_bytes;
      input [1:0] csize;
      input pair;
      begin
         if (pair)
            write_bytes = ONE_LVL + ONE_LVL;
         else
            write_bytes = ONE_LVL;
         if (csize == `UIES_CSIZE_PAIR)
            write_bytes = ONE_LVL + ONE_LVL;
      end
   endfunction

   // true when fewer than need bytes remain free above level
   function room_short;
      input [LVL_W-1:0] level;
      input [LVL_W-1:0] need;
      input [LVL_W-1:0] depth;
      begin
         room_short = ({1'b0, level} + {1'b0, need}) > {1'b0, depth};
      end
   endfunction

   reg [`UIES_EV_W-1:0] status_q;
   reg [`UIES_EV_W-1:0] status_d;
   reg [`UIES_EV_W-1:0] mask_q;
   reg [`UIES_EV_W-1:0] mask_d;
   reg [1:0] csize_q;
   reg [5:0] ttrig_q;
   reg paren_q;
   reg [3:0] modem_q;
   reg [`UIES_EV_W-1:0] ev;
   reg [`UIES_EV_W-1:0] clr;
   reg [31:0] rdata_d;
   reg [LVL_W-1:0] tx_push_bytes;
   reg [LVL_W-1:0] tx_after;
   reg [LVL_W-1:0] cfg_bytes;
   reg tx_nf_now;
   reg tx_ovf;

   wire wr_status = reg_wr_i && (reg_addr_i == `UIES_OFF_STATUS);
   wire wr_mask = reg_wr_i && (reg_addr_i == `UIES_OFF_MASK);
   wire wr_cfg = reg_wr_i && (reg_addr_i == `UIES_OFF_CFG);

   // transmit side event decode
   always @* begin
      tx_push_bytes = write_bytes(2'h3, tx_pair_i);
      cfg_bytes = write_bytes(csize_q, 1'b0);
      tx_nf_now = room_short(tx_level_i, cfg_bytes, TX_FULL_LVL);
      tx_ovf = tx_push_i && (tx_nf_now ||
         room_short(tx_level_i, tx_push_bytes, TX_FULL_LVL));
      if (tx_ovf)
         tx_after = tx_level_i;
      else
         tx_after = tx_level_i + tx_push_bytes;
   end

   // one-cycle event pulses
   always @* begin
      ev = {`UIES_EV_W{1'b0}};
      ev[`UIES_EV_TX_OVF] = tx_ovf;
      ev[`UIES_EV_TX_NFULL] = tx_push_i && !tx_ovf &&
         room_short(tx_after, cfg_bytes, TX_FULL_LVL);
      ev[`UIES_EV_TX_TRIG] = tx_push_i && !tx_ovf &&
         (tx_after == {{(LVL_W-6){1'b0}}, ttrig_q});
      ev[`UIES_EV_MODEM] = |(modem_delta_i & ~modem_q);
      ev[`UIES_EV_RX_TOUT] = rx_timeout_i;
      ev[`UIES_EV_RX_PAR] = rx_char_done_i && paren_q &&
         (rx_parity_bit_i != rx_parity_exp_i);
      ev[`UIES_EV_RX_FRAME] = rx_char_done_i && !rx_stop_bit_i;
      ev[`UIES_EV_RX_OVR] = rx_start_i && rx_shift_pending_i;
      ev[`UIES_EV_TX_FULL] = tx_push_i && !tx_ovf &&
         (tx_level_i != TX_FULL_LVL) && (tx_after == TX_FULL_LVL);
      ev[`UIES_EV_TX_EMPTY] = tx_pop_i && (tx_level_i == ONE_LVL);
      ev[`UIES_EV_RX_FULL] = rx_push_i &&
         (rx_level_i == RX_FULL_LVL - ONE_LVL);
      ev[`UIES_EV_RX_EMPTY] = rx_pop_i && (rx_level_i == ONE_LVL);
      ev[`UIES_EV_RX_TRIG] = rx_push_i;
   end

   // sticky status with write-one-to-clear, set beats clear
   always @* begin
      clr = wr_status ? reg_wdata_i[`UIES_EV_W-1:0] : {`UIES_EV_W{1'b0}};
      status_d = (status_q & ~clr) | ev;
      mask_d = wr_mask ? reg_wdata_i[`UIES_EV_W-1:0] : mask_q;
   end

   // read mux, unmapped and upper bits read zero
   always @* begin
      rdata_d = 32'h0000_0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `UIES_OFF_STATUS: begin
               rdata_d[`UIES_EV_W-1:0] = status_q;
            end
            `UIES_OFF_MASK: begin
               rdata_d[`UIES_EV_W-1:0] = mask_q;
            end
            `UIES_OFF_CFG: begin
               rdata_d[`UIES_CFG_CSIZE_MSB:`UIES_CFG_CSIZE_LSB] = csize_q;
               rdata_d[`UIES_CFG_TTRIG_MSB:`UIES_CFG_TTRIG_LSB] = ttrig_q;
               rdata_d[`UIES_CFG_PAREN] = paren_q;
            end
            `UIES_OFF_LEVEL: begin
               rdata_d[LVL_W-1:0] = tx_level_i;
               rdata_d[LVL_W+15:16] = rx_level_i;
            end
            default: begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_q <= `UIES_STATUS_RST;
         mask_q <= `UIES_MASK_RST;
         csize_q <= `UIES_CSIZE_RST;
         ttrig_q <= `UIES_TTRIG_RST;
         paren_q <= `UIES_PAREN_RST;
         modem_q <= 4'h0;
         irq_o <= 1'b0;
         reg_rdata_o <= 32'h0000_0000;
         tx_nearly_full_o <= 1'b0;
         char_size_o <= `UIES_CSIZE_RST;
         tx_trig_level_o <= `UIES_TTRIG_RST;
      end else begin
         status_q <= status_d;
         mask_q <= mask_d;
         modem_q <= modem_delta_i;
         if (wr_cfg) begin
            csize_q <= reg_wdata_i[`UIES_CFG_CSIZE_MSB:`UIES_CFG_CSIZE_LSB];
            ttrig_q <= reg_wdata_i[`UIES_CFG_TTRIG_MSB:`UIES_CFG_TTRIG_LSB];
            paren_q <= reg_wdata_i[`UIES_CFG_PAREN];
            char_size_o <= reg_wdata_i[`UIES_CFG_CSIZE_MSB:`UIES_CFG_CSIZE_LSB];
            tx_trig_level_o <= reg_wdata_i[`UIES_CFG_TTRIG_MSB:`UIES_CFG_TTRIG_LSB];
         end
         irq_o <= |(status_d & mask_d);
         reg_rdata_o <= rdata_d;
         tx_nearly_full_o <= tx_nf_now;
      end
   end

endmodule // uies_top

// ---- verif/uies_top_props.sv ----
// checker of the event status block
`timescale 1ns/1ps
module uies_top_props #(parameter LVL_W = 7) (
   input logic sys_clk_i,
   input logic rst_b_i,
   input logic [7:0] reg_addr_i,
   input logic [31:0] reg_wdata_i,
   input logic reg_wr_i,
   input logic reg_rd_i,
   input logic [31:0] reg_rdata_o,
   input logic tx_pop_i,
   input logic [LVL_W-1:0] tx_level_i,
   input logic rx_push_i,
   input logic rx_pop_i,
   input logic [LVL_W-1:0] rx_level_i,
   input logic rx_start_i,
   input logic rx_shift_pending_i,
   input logic rx_char_done_i,
   input logic rx_stop_bit_i,
   input logic rx_timeout_i,
   input logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence rd0; reg_rd_i && reg_addr_i == 8'h00; endsequence
   AST_RX_TRIG: assert property (rx_push_i ##1 rd0 |=> reg_rdata_o[0]) else $error("b0");
   AST_RX_EMPTY: assert property (rx_pop_i && rx_level_i == 1 ##1 rd0 |=> reg_rdata_o[1])
      else $error("b1");
   AST_RX_FULL: assert property (rx_push_i && rx_level_i == 63 ##1 rd0 |=> reg_rdata_o[2])
      else $error("b2");
   AST_TX_EMPTY: assert property (tx_pop_i && tx_level_i == 1 ##1 rd0 |=> reg_rdata_o[3])
      else $error("b3");
   AST_OVR: assert property (rx_start_i && rx_shift_pending_i ##1 !reg_wr_i ##1 rd0
      |=> reg_rdata_o[5]) else $error("b5");
   AST_FRAME: assert property (rx_char_done_i && !rx_stop_bit_i ##1 rd0 |=> reg_rdata_o[6])
      else $error("b6");
   AST_TOUT: assert property (rx_timeout_i ##1 rd0 |=> reg_rdata_o[8]) else $error("b8");
   AST_UPPER: assert property (rd0 |=> reg_rdata_o[31:13] == 0) else $error("upper");
   AST_CLEAR: assert property (reg_wr_i && reg_addr_i == 0 && reg_wdata_i[0] && !rx_push_i
      ##1 rd0 |=> !reg_rdata_o[0]) else $error("clear");
   AST_NO_IRQ: assert property (reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[12:0] == 0
      |=> !irq_o) else $error("irq");
   cover property (rd0 ##1 reg_rdata_o[12]);
   cover property ($rose(irq_o));
   cover property (rx_char_done_i && !rx_stop_bit_i);
endmodule // uies_top_props
bind uies_top uies_top_props #(.LVL_W(LVL_W)) u_props (.*);

// ---- verif/uies_peer.sv ----
// remote serial peer model: start bit then a finished character
`timescale 1ns/1ps
module uies_peer (
   input logic clk_i,
   input logic go_i,
   input logic par_i,
   input logic bad_stop_i,
   output logic start_o,
   output logic done_o,
   output logic par_o,
   output logic stop_o
);
   logic [1:0] ph_q = 2'h0;
   always @(posedge clk_i) begin
      ph_q <= {ph_q[0], go_i};
   end
   assign start_o = ph_q[0];
   assign done_o = ph_q[1];
   // outside a character the inverse is shown
   assign par_o = ~(done_o ^ par_i);
   assign stop_o = done_o ^ bad_stop_i;
endmodule // uies_peer

// ---- verif/tb_uies_top.sv ----
// self-checking bench of the event status block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_uies_top;
   logic sys_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, go = 0, bp = 0, bs = 0, pexp = 0;
   logic [7:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, reg_rdata_o;
   logic [10:0] ev = 0;
   logic [6:0] tl = 0, rl = 0;
   logic irq_o, nf, st, dn, par, stp;
   logic [1:0] cs;
   logic [5:0] tt;
   int err_count = 0, n_tests = 0;
   uies_top dut (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .tx_push_i(ev[0]), .tx_pair_i(ev[1]), .tx_pop_i(ev[2]), .tx_level_i(tl),
      .rx_push_i(ev[3]), .rx_pop_i(ev[4]), .rx_level_i(rl), .rx_start_i(st),
      .rx_shift_pending_i(ev[5]), .rx_char_done_i(dn), .rx_parity_bit_i(par),
      .rx_parity_exp_i(pexp), .rx_stop_bit_i(stp), .rx_timeout_i(ev[6]), .modem_delta_i(ev[10:7]),
      .irq_o, .tx_nearly_full_o(nf), .char_size_o(cs), .tx_trig_level_o(tt));
   uies_peer peer (.clk_i(sys_clk_i), .go_i(go), .par_i(bp), .bad_stop_i(bs), .start_o(st),
      .done_o(dn), .par_o(par), .stop_o(stp));
   initial forever #5 sys_clk_i = ~sys_clk_i;
   function automatic [12:0] expv(input [10:0] e, input int t, q, input [1:0] c, input [5:0] g);
      int nd, by;
      logic ov;
      nd = (c == 0) ? 2 : 1;
      by = e[1] ? 2 : 1;
      ov = e[0] && (t + nd > 64 || t + by > 64);
      by = ov ? 0 : by;
      expv = 0;
      expv[12:10] = {ov, e[0] && !ov && t + by + nd > 64, e[0] && !ov && t + by == g};
      expv[9:8] = {|e[10:7], e[6]};
      expv[4] = e[0] && !ov && t != 64 && t + by == 64;
      expv[3:0] = {e[2] && t == 1, e[3] && q == 63, e[4] && q == 1, e[3]};
   endfunction
   task wr(input [7:0] a, input [31:0] d);
      @(posedge sys_clk_i) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {2'b10, a, d};
   endtask
   task rd(input [7:0] a, input [31:0] x);
      @(posedge sys_clk_i) {reg_wr_i, reg_rd_i, reg_addr_i, ev} <= {2'b01, a, 11'h0};
      @(posedge sys_clk_i) reg_rd_i <= 0;
      #1 `CHK(reg_rdata_o, x)
   endtask
   task close_out();
      $display("tests=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      close_out();
   end
   initial begin
      logic [12:0] m, x;
      logic [10:0] r;
      int t, q;
      logic [1:0] c;
      logic [5:0] g;
      void'($urandom(32'h542625B5));
      repeat (3) @(posedge sys_clk_i);
      rst_b_i <= 1;
      `CHK({cs, tt}, 8'hE0)
      rd(8'h00, 0);
      wr(8'h10, '1);
      rd(8'h10, 0);
      for (int i = 0; i < 200; i++) begin
         c = $urandom;
         m = $urandom;
         r = $urandom;
         t = i[0] ? 64 - $urandom_range(0, 3) : i[1] ? 1 : $urandom_range(0, 64);
         q = i[1] ? (i[2] ? 63 : 1) : $urandom_range(0, 64);
         g = i[2] ? t + 2 : $urandom;
         wr(8'h08, {g, 6'h0, c});
         wr(8'h04, m);
         @(posedge sys_clk_i) {reg_wr_i, ev, tl, rl} <= {1'b0, r, t[6:0], q[6:0]};
         x = expv(r, t, q, c, g);
         rd(8'h00, x);
         `CHK(irq_o, |(x & m))
         `CHK({cs, tt}, {c, g})
         `CHK(nf, (t + ((c == 0) ? 2 : 1)) > 64)
         wr(8'h00, 0);
         rd(8'h00, x);
         wr(8'h00, x);
         rd(8'h00, 0);
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h08, {i[2], 16'h0});
         wr(8'h00, 32'h1FFF);
         pexp <= $urandom;
         @(posedge sys_clk_i) {reg_wr_i, go, bs, ev[5]} <= {2'b01, i[1], i[0] ^ i[1]};
         bp <= pexp ^ i[0];
         @(posedge sys_clk_i) go <= 0;
         @(posedge sys_clk_i);
         rd(8'h00, {i[0] & i[2], i[1], i[0] ^ i[1], 5'h0});
      end
      wr(8'h04, '1);
      rd(8'h04, 32'h1FFF);
      `CHK(irq_o, 1'b1)
      wr(8'h04, 0);
      rd(8'h04, 0);
      `CHK(irq_o, 1'b0)
      close_out();
   end
endmodule // tb_uies_top
